// ==== hall_cal_pkg.sv ====
`default_nettype none
package hall_cal_pkg;
    // Register byte addresses on the serial register port.
    localparam logic [7:0] REG_PLATE_ONE_TUNING = 8'h72;
    localparam logic [7:0] REG_PLATE_TWO_TUNING = 8'h73;
    localparam logic [7:0] REG_PHASE_COSINE     = 8'h79;
    localparam logic [7:0] REG_PHASE_SINE       = 8'h7A;
    localparam logic [7:0] REG_INDEX_POINTER    = 8'hF0;
    localparam logic [7:0] REG_DATA_WINDOW      = 8'hF1;
    // Indirect index of trim word three.
    localparam logic [7:0] IDX_TRIM_WORD_THREE  = 8'h13;
    // Bin field and its legal range.
    localparam int         BIN_LSB              = 0;
    localparam int         BIN_WIDTH            = 4;
    localparam logic [3:0] BIN_MIN              = 4'h1;
    localparam logic [3:0] BIN_MAX              = 4'hF;
    // Reset values.
    localparam logic [7:0] RST_TUNING           = 8'h00;
    localparam logic [7:0] RST_COSINE           = 8'h00;
    localparam logic [7:0] RST_SINE             = 8'h00;
    localparam logic [7:0] RST_POINTER          = 8'h00;
    localparam logic [7:0] RST_TRIM             = 8'h00;
    // Size of the indirect space held by this block.
    localparam int         IND_DEPTH            = 256;
    localparam logic [15:0] RST_CHANNEL         = 16'h0000;
endpackage
`default_nettype wire

// ==== channel_pair.sv ====
`timescale 1ns/1ps
`default_nettype none
module channel_pair
    import hall_cal_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // Plate sample and tuning setting.
    input  wire logic [15:0] field_in,
    input  wire logic        sample_in,
    input  wire logic [7:0]  tuning_in,
    // Channel outputs.
    output logic      [15:0] direct_out,
    output logic      [15:0] inverted_out
);
    // Tuning offsets both channels alike so the pair stays mirrored.
    wire logic [15:0] offset_w   = {8'h00, tuning_in};
    wire logic [15:0] direct_w   = field_in + offset_w;
    wire logic [15:0] inverted_w = ~field_in + offset_w;

    // Both channels sample together so the pair never tears.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            direct_out   <= RST_CHANNEL;
            inverted_out <= RST_CHANNEL;
        end else if (sample_in) begin
            direct_out   <= direct_w;
            inverted_out <= inverted_w;
        end
    end

    mirror_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        sample_in |=> (direct_out + inverted_out == {7'h00, $past(tuning_in), 1'b0} + 16'hFFFF))
        else $error("Inverted channel does not mirror the direct channel.");
endmodule
`default_nettype wire

// ==== hall_calibration_setup.sv ====
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Factory bin index lies between one and fifteen.
// - Bin index sits in the low nibble of trim word three.
// - Pointer 0x13 at 0xF0, then a read of 0xF1 returns the trim word.
// - Plate one direct on channel two, inverted on channel three.
// - Plate two direct on channel four, inverted on channel five.
// - Inverted channel falls when the direct channel rises.
// - Phase held as sine and cosine scaled by 256, used in angle maths.
// - Pointer then data write in one transfer stores at the index; the code drops a write at the trim word index 0x13.
module hall_calibration_setup
    import hall_cal_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // Register port from the serial interface engine.
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    // Factory bin strap, sampled once after reset.
    input  wire logic [3:0]  factory_bin_in,
    // Plate samples.
    input  wire logic [15:0] plate_one_field_in,
    input  wire logic [15:0] plate_two_field_in,
    input  wire logic        sample_in,
    // Register read data.
    output logic      [7:0]  reg_rdata_out,
    output logic             reg_rvalid_out,
    // Measurement channels.
    output logic      [15:0] plate_one_direct_channel_out,
    output logic      [15:0] plate_one_inverted_channel_out,
    output logic      [15:0] plate_two_direct_channel_out,
    output logic      [15:0] plate_two_inverted_channel_out,
    // Phase constants as used by the angle engine.
    output logic      [7:0]  angle_cosine_out,
    output logic      [7:0]  angle_sine_out
);
    logic [7:0] tune_one_q;
    logic [7:0] tune_two_q;
    logic [7:0] cosine_q;
    logic [7:0] sine_q;
    logic [7:0] pointer_q;
    logic [7:0] trim_q;
    logic       trim_loaded_q;
    logic [7:0] ind_mem_q [IND_DEPTH];

    // Clamp the strap to the legal bin range so a blank strap still reads a legal bin.
    function automatic logic [3:0] legal_bin(input logic [3:0] raw);
        legal_bin = (raw < BIN_MIN) ? BIN_MIN : raw;
    endfunction

    // Write strobes per register.
    wire logic wr_tune_one_w = reg_wr_in && (reg_addr_in == REG_PLATE_ONE_TUNING);
    wire logic wr_tune_two_w = reg_wr_in && (reg_addr_in == REG_PLATE_TWO_TUNING);
    wire logic wr_cosine_w   = reg_wr_in && (reg_addr_in == REG_PHASE_COSINE);
    wire logic wr_sine_w     = reg_wr_in && (reg_addr_in == REG_PHASE_SINE);
    wire logic wr_pointer_w  = reg_wr_in && (reg_addr_in == REG_INDEX_POINTER);
    wire logic wr_window_w   = reg_wr_in && (reg_addr_in == REG_DATA_WINDOW);
    // The trim word is read-only; a write to its index is dropped.
    wire logic trim_sel_w    = (pointer_q == IDX_TRIM_WORD_THREE);

    // Any address outside the six registers reads as zero and ignores writes.
    wire logic addr_mapped_w =
        (reg_addr_in == REG_PLATE_ONE_TUNING) || (reg_addr_in == REG_PLATE_TWO_TUNING) ||
        (reg_addr_in == REG_PHASE_COSINE)     || (reg_addr_in == REG_PHASE_SINE)       ||
        (reg_addr_in == REG_INDEX_POINTER)    || (reg_addr_in == REG_DATA_WINDOW);

    // Indirect read selects the trim word or the scratch array.
    wire logic [7:0] window_rd_w = trim_sel_w ? trim_q : ind_mem_q[pointer_q];
    wire logic [7:0] rd_mux_w =
        (reg_addr_in == REG_PLATE_ONE_TUNING) ? tune_one_q :
        (reg_addr_in == REG_PLATE_TWO_TUNING) ? tune_two_q :
        (reg_addr_in == REG_PHASE_COSINE)     ? cosine_q   :
        (reg_addr_in == REG_PHASE_SINE)       ? sine_q     :
        (reg_addr_in == REG_INDEX_POINTER)    ? pointer_q  :
        (reg_addr_in == REG_DATA_WINDOW)      ? window_rd_w : 8'h00;

    // The strap is caught by a clocked load after release, never by the reset itself.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            trim_q        <= RST_TRIM;
            trim_loaded_q <= 1'b0;
        end else if (!trim_loaded_q) begin
            trim_q        <= {4'h0, legal_bin(factory_bin_in)};
            trim_loaded_q <= 1'b1;
        end
    end

    // Direct configuration registers; no reset needed to take effect.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tune_one_q <= RST_TUNING;
            tune_two_q <= RST_TUNING;
            cosine_q   <= RST_COSINE;
            sine_q     <= RST_SINE;
        end else begin
            if (wr_tune_one_w) tune_one_q <= reg_wdata_in;
            if (wr_tune_two_w) tune_two_q <= reg_wdata_in;
            if (wr_cosine_w)   cosine_q   <= reg_wdata_in;
            if (wr_sine_w)     sine_q     <= reg_wdata_in;
        end
    end

    // Pointer stays put after a window access so a split transfer reads the same word.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pointer_q <= RST_POINTER;
        end else if (wr_pointer_w) begin
            pointer_q <= reg_wdata_in;
        end
    end

    // Scratch indirect space; it has no reset, so reads before a write are undefined.
    always_ff @(posedge clk_in) begin
        if (wr_window_w && !trim_sel_w) begin
            ind_mem_q[pointer_q] <= reg_wdata_in;
        end
    end

    // Read answer one cycle after the strobe.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out  <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) reg_rdata_out <= rd_mux_w;
        end
    end

    // Phase constants are copied registered to the angle engine.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            angle_cosine_out <= RST_COSINE;
            angle_sine_out   <= RST_SINE;
        end else begin
            angle_cosine_out <= cosine_q;
            angle_sine_out   <= sine_q;
        end
    end

    // Plate one drives channels two and three.
    channel_pair plate_one_pair (
        .clk_in       (clk_in),
        .sys_rst_in   (sys_rst_in),
        .field_in     (plate_one_field_in),
        .sample_in    (sample_in),
        .tuning_in    (tune_one_q),
        .direct_out   (plate_one_direct_channel_out),
        .inverted_out (plate_one_inverted_channel_out)
    );

    // Plate two drives channels four and five.
    channel_pair plate_two_pair (
        .clk_in       (clk_in),
        .sys_rst_in   (sys_rst_in),
        .field_in     (plate_two_field_in),
        .sample_in    (sample_in),
        .tuning_in    (tune_two_q),
        .direct_out   (plate_two_direct_channel_out),
        .inverted_out (plate_two_inverted_channel_out)
    );

    bin_range_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        trim_loaded_q |-> (trim_q[3:0] >= BIN_MIN && trim_q[7:4] == 4'h0))
        else $error("Bin index out of range.");
    trim_read_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (reg_rd_in && reg_addr_in == REG_DATA_WINDOW && trim_sel_w && trim_loaded_q)
        |=> (reg_rvalid_out && reg_rdata_out == trim_q))
        else $error("Trim word read returned wrong data.");
    pointer_load_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_pointer_w |=> pointer_q == $past(reg_wdata_in))
        else $error("Pointer did not load.");
    ind_store_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_window_w && !trim_sel_w) |=> ind_mem_q[$past(pointer_q)] == $past(reg_wdata_in))
        else $error("Indirect write not stored.");
    tune_route_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_tune_two_w |=> (tune_two_q == $past(reg_wdata_in)) && $stable(tune_one_q))
        else $error("Plate tuning write went to the wrong plate.");
    cos_apply_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_cosine_w |=> ##1 angle_cosine_out == $past(reg_wdata_in, 2))
        else $error("Cosine constant not applied.");
    sine_apply_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_sine_w |=> ##1 angle_sine_out == $past(reg_wdata_in, 2))
        else $error("Sine constant not applied.");
    unmapped_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (reg_rd_in && !addr_mapped_w) |=> reg_rdata_out == 8'h00)
        else $error("Unmapped read not zero.");

    // Read answer timing, tuning write routing and plate channel routing, checked against the register port and plate inputs.
    read_answer_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        reg_rd_in |=> reg_rvalid_out)
        else $error("Read answer missing one cycle after the strobe.");
    read_idle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !reg_rd_in |=> !reg_rvalid_out)
        else $error("Read answer raised without a strobe.");
    tune_one_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_tune_one_w |=> (tune_one_q == $past(reg_wdata_in)) && $stable(tune_two_q))
        else $error("Plate one tuning write went to the wrong plate.");
    plate_one_route_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        sample_in |=> plate_one_direct_channel_out
            == $past(plate_one_field_in) + {8'h00, $past(tune_one_q)})
        else $error("Plate one direct channel mis-routed.");
    plate_two_route_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        sample_in |=> plate_two_direct_channel_out
            == $past(plate_two_field_in) + {8'h00, $past(tune_two_q)})
        else $error("Plate two direct channel mis-routed.");

    trim_cover_c: cover property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_pointer_w && reg_wdata_in == IDX_TRIM_WORD_THREE ##[1:20]
        (reg_rd_in && reg_addr_in == REG_DATA_WINDOW));
    ind_cover_c: cover property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_pointer_w ##1 wr_window_w);
    phase_cover_c: cover property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_cosine_w ##[1:20] wr_sine_w);
    tune_cover_c: cover property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_tune_one_w ##[1:20] wr_tune_two_w);
endmodule
`default_nettype wire

// ==== host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model
    import hall_cal_pkg::*;
(
    // Clock and read answer.
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in,
    // Register requests.
    output logic      [7:0] addr_out,
    output logic      [7:0] wdata_out,
    output logic            wr_out,
    output logic            rd_out
);
    // Per-bin tuning tables as a product would export them.
    localparam logic [7:0] ONE_TBL [15] = '{8'hD0, 8'hD3, 8'hD5, 8'hD6, 8'hD8, 8'hD0, 8'hD3,
        8'hD5, 8'hD6, 8'hD8, 8'hD0, 8'hD3, 8'hD5, 8'hD6, 8'hD8};
    localparam logic [7:0] TWO_TBL [15] = '{8'hCF, 8'hD1, 8'hD3, 8'hD4, 8'hD6, 8'hD0, 8'hD2,
        8'hD4, 8'hD6, 8'hD7, 8'hD2, 8'hD4, 8'hD6, 8'hD8, 8'hD9};
    // Flags register polled before stored compensation; the busy bit position is a plain default.
    localparam logic [7:0] FLAGS_REG = 8'h10;
    localparam int         BUSY_BIT  = 0;
    logic [7:0] cal_word;

    // The bus idles with all strobes low.
    initial begin
        addr_out  = 8'h00;
        wdata_out = 8'h00;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
    end

    // A released bus shows inverted values so a stale address never looks valid.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge clk_in);
        wr_out    <= 1'b0;
        addr_out  <= ~a;
        wdata_out <= ~d;
    endtask

    // The answer is awaited for a few cycles only, so a silent device reads as unknown.
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        d = 'x;
        @(posedge clk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge clk_in);
        rd_out   <= 1'b0;
        addr_out <= ~a;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_in);
            if (rvalid_in === 1'b1) begin
                d = rdata_in;
                break;
            end
        end
    endtask

    // Compensation goes through the window once the busy bit reads clear, or regardless after eight polls.
    task automatic write_comp(input logic [7:0] idx, input logic [7:0] val);
        logic [7:0] flags;
        flags = 8'hFF;
        for (int i = 0; i < 8 && flags[BUSY_BIT] !== 1'b0; i++) begin
            read_reg(FLAGS_REG, flags);
        end
        write_reg(REG_INDEX_POINTER, idx);
        write_reg(REG_DATA_WINDOW, val);
    endtask

    // Start-up sequence run once after power-up, before normal use.
    task automatic run_setup(input logic [7:0] cos_c, input logic [7:0] sin_c,
                             output logic [3:0] bin);
        write_reg(REG_INDEX_POINTER, IDX_TRIM_WORD_THREE);
        read_reg(REG_DATA_WINDOW, cal_word);
        bin = cal_word[3:0];
        if (bin != 4'h0) begin
            write_reg(REG_PLATE_ONE_TUNING, ONE_TBL[int'(bin) - 1]);
            write_reg(REG_PLATE_TWO_TUNING, TWO_TBL[int'(bin) - 1]);
        end
        write_reg(REG_PHASE_COSINE, cos_c);
        write_reg(REG_PHASE_SINE, sin_c);
    endtask
endmodule
`default_nettype wire

// ==== tb_hall_calibration_setup.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) check_val(nm, 16'(e), 16'(g));
module tb_hall_calibration_setup
    import hall_cal_pkg::*;
;
    logic        clk_in = 1'b0, sys_rst_in = 1'b1, wr, rd, sample_in = 1'b0, rvalid;
    logic [3:0]  strap = 4'h7, bin_v;
    logic [7:0]  addr, wdata, rdata, cos_o, sin_o, rd_v;
    logic [15:0] f1 = 16'h0000, f2 = 16'h0000, d1, i1, d2, i2, prev;
    int          fail_count = 0, num_checks = 0;

    // Clock at 40 MHz.
    always #12.5 clk_in = ~clk_in;

    hall_calibration_setup hall_calibration_setup_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .factory_bin_in(strap), .plate_one_field_in(f1), .plate_two_field_in(f2),
        .sample_in(sample_in), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .plate_one_direct_channel_out(d1), .plate_one_inverted_channel_out(i1),
        .plate_two_direct_channel_out(d2), .plate_two_inverted_channel_out(i2),
        .angle_cosine_out(cos_o), .angle_sine_out(sin_o));
    host_model host_model_inst (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid),
        .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

    task automatic check_val(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Reset is held for eight cycles; requests start from the second edge after release.
    task automatic do_reset(input logic [3:0] s);
        @(posedge clk_in);
        strap      <= s;
        sys_rst_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
        host_model_inst.read_reg(a, rd_v);
        `CHK(nm, e, rd_v)
    endtask

    // One sample pulse, then all four channels against the field, or its complement for the inverted ones, plus the plate tuning.
    task automatic sample_chk(input logic [15:0] a, input logic [15:0] b,
                              input logic [7:0] t1, input logic [7:0] t2);
        @(posedge clk_in);
        f1        <= a;
        f2        <= b;
        sample_in <= 1'b1;
        @(posedge clk_in);
        sample_in <= 1'b0;
        @(negedge clk_in);
        `CHK("plate one direct", a + {8'h00, t1}, d1)
        `CHK("plate one inverted", ~a + {8'h00, t1}, i1)
        `CHK("plate two direct", b + {8'h00, t2}, d2)
        `CHK("plate two inverted", ~b + {8'h00, t2}, i2)
    endtask

    // Watchdog far beyond the couple of hundred cycles the tests need.
    initial begin
        #200000;
        fail_count++;
        test_done();
    end

    // Main sequence of tests.
    initial begin
        logic [7:0] regs [6];
        regs = '{REG_PLATE_ONE_TUNING, REG_PLATE_TWO_TUNING, REG_PHASE_COSINE, REG_PHASE_SINE,
                 REG_INDEX_POINTER, 8'h20};
        do_reset(4'h7);
        foreach (regs[k]) rd_chk("reset value", regs[k], 8'h00);
        `CHK("cosine out", 8'h00, cos_o)
        $display("reset test done");
        host_model_inst.run_setup(8'h83, 8'hDA, bin_v);
        `CHK("bin", 4'h7, bin_v)
        rd_chk("plate one tuning", REG_PLATE_ONE_TUNING, 8'hD3);
        rd_chk("plate two tuning", REG_PLATE_TWO_TUNING, 8'hD2);
        repeat (2) @(negedge clk_in);
        `CHK("cosine out", 8'h83, cos_o)
        `CHK("sine out", 8'hDA, sin_o)
        $display("setup test done");
        sample_chk(16'h1000, 16'h2000, 8'hD3, 8'hD2);
        `CHK("direct pair delta", 16'h1000, (d2 - 16'h00D2) - (d1 - 16'h00D3))
        `CHK("inverted pair delta", 16'h1000, (i1 - 16'h00D3) - (i2 - 16'h00D2))
        prev = i1;
        sample_chk(16'h1100, 16'h2100, 8'hD3, 8'hD2);
        `CHK("inverted falls", 1'b1, i1 < prev)
        host_model_inst.write_reg(REG_PLATE_ONE_TUNING, 8'h05);
        host_model_inst.write_reg(REG_PLATE_TWO_TUNING, 8'hFF);
        sample_chk(16'hFF00, 16'h0000, 8'h05, 8'hFF);
        $display("channel test done");
        host_model_inst.write_comp(8'h40, 8'h5A);
        host_model_inst.write_comp(8'h41, 8'hA5);
        host_model_inst.write_reg(REG_INDEX_POINTER, 8'h40);
        rd_chk("indirect data", REG_DATA_WINDOW, 8'h5A);
        rd_chk("pointer", REG_INDEX_POINTER, 8'h40);
        host_model_inst.write_reg(8'h20, 8'h77);
        rd_chk("unmapped write", 8'h20, 8'h00);
        host_model_inst.write_reg(REG_INDEX_POINTER, IDX_TRIM_WORD_THREE);
        host_model_inst.write_reg(REG_DATA_WINDOW, 8'hEE);
        host_model_inst.read_reg(REG_DATA_WINDOW, rd_v);
        `CHK("trim after write", 4'h7, rd_v[3:0])
        $display("indirect test done");
        for (int s = 0; s < 3; s++) begin
            do_reset(s == 0 ? 4'h0 : (s == 1 ? 4'h1 : 4'hF));
            host_model_inst.write_reg(REG_INDEX_POINTER, IDX_TRIM_WORD_THREE);
            host_model_inst.read_reg(REG_DATA_WINDOW, rd_v);
            `CHK("bin range", s == 2 ? 4'hF : 4'h1, rd_v[3:0])
        end
        $display("bin test done");
        test_done();
    end
endmodule
`undef CHK
`default_nettype wire
